// File: rtl/nab_alu.sv
// Nibble ALU datapath with binary/decimal arithmetic, flags and skip logic
//
// Behaviour
// - Decimal flag clear: plain binary add/subtract
// - Decimal flag set: correct result before storing
// - Decimal sums 10-19: minus ten, carry set
// - Decimal sums 20-31: carry, fixed out-of-range codes
// - Decimal differences: -10..-1 plus ten, else codes
// - Latch both operands into temporaries first
// - First from register/memory, second from memory/immediate
// - Register-memory and memory-immediate operand forms
// - Rotate uses only the general register operand
// - Write result back to first operand location
// - Bit-test and compare store nothing, may skip
// - Logical ops ignore modes, keep carry, zero
// - Bit tests clear the compare-only flag
// - Index-modify enable steers operand addressing
// - Add, add-carry, subtract, subtract-borrow provided
// - Compare-only flag blocks arithmetic write-back
// - Binary carry on overflow or borrow, low nibble
// - Compare-only clear: zero flag tracks zero result
// - Add-with-carry uses then replaces carry flag
// - Carry and borrow share one flag
// - Compare-only set: zero held on zero, else cleared
// - Rotate: old carry to bit 3, bit 0 to carry
// - Only arithmetic and rotate change carry
// - Only arithmetic changes zero
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module nab_alu
  import nab_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire nab_op_t op_i,
  input wire logic form_i,
  input wire logic [3:0] reg_data_i,
  input wire logic [3:0] mem_data_i,
  input wire logic [3:0] imm_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [3:0] reg_rdata_o,
  output logic done_o,
  output logic [3:0] result_o,
  output logic wb_en_o,
  output logic wb_to_reg_o,
  output logic skip_o,
  output logic index_mod_o,
  output logic carry_flag_o,
  output logic zero_flag_o
);

  nab_state_t state_q;
  nab_op_t op_q;
  logic form_q;
  logic [3:0] temp_a_q;
  logic [3:0] temp_b_q;
  logic carry_flag_q;
  logic zero_flag_q;
  logic compare_only_flag_q;
  logic index_modify_enable_q;
  logic decimal_mode_q;

  logic exec;
  logic is_add;
  logic is_sub;
  logic is_arith;
  logic is_logic;
  logic is_test;
  logic is_cmp;
  logic is_rot;
  logic cin;
  logic [4:0] sum_ab;
  logic [4:0] raw;
  logic [4:0] cmp_raw;
  logic [3:0] arith_res;
  logic arith_cy;
  logic [3:0] alu_res;
  logic alu_skip;
  logic sw_status_wr;

  assign exec = (state_q == NAB_ST_EXEC);
  assign sw_status_wr = reg_wr_i && (reg_addr_i == NAB_ADDR_STATUS);

  // Operation class decode
  always_comb
  begin
    is_add = (op_q == NAB_OP_ADD) || (op_q == NAB_OP_SUM_WITH_CARRY_IN);
    is_sub = (op_q == NAB_OP_SUB) || (op_q == NAB_OP_DIFFERENCE_WITH_BORROW_IN);
    is_arith = is_add || is_sub;
    is_logic = (op_q == NAB_OP_AND) || (op_q == NAB_OP_OR) || (op_q == NAB_OP_XOR);
    is_test = (op_q == NAB_OP_TEST_TRUE) || (op_q == NAB_OP_TEST_FALSE);
    is_cmp = (op_q == NAB_OP_SKIP_EQ) || (op_q == NAB_OP_SKIP_NE) ||
             (op_q == NAB_OP_SKIP_GE) || (op_q == NAB_OP_SKIP_LT);
    is_rot = (op_q == NAB_OP_ROTATE_RIGHT_THROUGH_CARRY);
  end

  // Carry enters only the carry variants, sampled at execution
  assign cin = ((op_q == NAB_OP_SUM_WITH_CARRY_IN) ||
                (op_q == NAB_OP_DIFFERENCE_WITH_BORROW_IN)) && carry_flag_q;
  assign sum_ab = {1'b0, temp_a_q} + {1'b0, temp_b_q};
  // Five-bit raw value; bit 4 is the carry or the borrow
  assign raw = is_add ? (sum_ab + {4'h0, cin}) :
               ({1'b0, temp_a_q} - {1'b0, temp_b_q} - {4'h0, cin});
  assign cmp_raw = {1'b0, temp_a_q} - {1'b0, temp_b_q};

  // Binary or decimal-corrected arithmetic
  always_comb
  begin
    arith_res = raw[3:0];
    arith_cy = raw[4];
    if (decimal_mode_q)
    begin
      if (is_add)
      begin
        if (raw < NAB_DEC_TEN)
        begin
          arith_cy = 1'b0;
        end
        else if (raw < NAB_DEC_LIMIT)
        begin
          arith_res = 4'(raw - NAB_DEC_TEN);
          arith_cy = 1'b1;
        end
        else if (raw < NAB_DEC_HIGH)
        begin
          arith_res = {NAB_DEC_TOP, raw[1:0] ^ NAB_DEC_FOLD};
          arith_cy = 1'b1;
        end
        else
        begin
          arith_res = 4'(raw - NAB_DEC_HIGH_OFS);
          arith_cy = 1'b1;
        end
      end
      else
      begin
        // Negative side -10..-1 is raw 22..31 in five bits
        if (!raw[4] && (raw < NAB_DEC_TEN))
        begin
          arith_cy = 1'b0;
        end
        else if (raw[4] && (raw[3:0] > 4'h5))
        begin
          arith_res = 4'(raw[3:0] + NAB_DEC_TEN[3:0]);
          arith_cy = 1'b1;
        end
        else
        begin
          arith_res = {NAB_DEC_TOP, raw[1:0] ^ NAB_DEC_FOLD};
          arith_cy = 1'b1;
        end
      end
    end
  end

  // Result and skip selection
  always_comb
  begin
    alu_res = arith_res;
    alu_skip = 1'b0;
    case (op_q)
      NAB_OP_AND: alu_res = temp_a_q & temp_b_q;
      NAB_OP_OR: alu_res = temp_a_q | temp_b_q;
      NAB_OP_XOR: alu_res = temp_a_q ^ temp_b_q;
      NAB_OP_TEST_TRUE: alu_skip = ((temp_a_q & temp_b_q) == temp_b_q);
      NAB_OP_TEST_FALSE: alu_skip = ((temp_a_q & temp_b_q) == NAB_NIBBLE_ZERO);
      NAB_OP_SKIP_EQ: alu_skip = (cmp_raw[3:0] == NAB_NIBBLE_ZERO);
      NAB_OP_SKIP_NE: alu_skip = (cmp_raw[3:0] != NAB_NIBBLE_ZERO);
      NAB_OP_SKIP_GE: alu_skip = !cmp_raw[4];
      NAB_OP_SKIP_LT: alu_skip = cmp_raw[4];
      NAB_OP_ROTATE_RIGHT_THROUGH_CARRY: alu_res = {carry_flag_q, temp_a_q[3:1]};
      default: alu_res = arith_res;
    endcase
  end

  // Sequencer: a request is latched, then executed the next cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= NAB_ST_IDLE;
    end
    else
    begin
      case (state_q)
        NAB_ST_IDLE: state_q <= start_i ? NAB_ST_EXEC : NAB_ST_IDLE;
        NAB_ST_EXEC: state_q <= start_i ? NAB_ST_EXEC : NAB_ST_IDLE;
        default: state_q <= NAB_ST_IDLE;
      endcase
    end
  end

  // Operand temporaries
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      op_q <= NAB_OP_ADD;
      form_q <= NAB_FORM_REG_MEM;
      temp_a_q <= NAB_NIBBLE_ZERO;
      temp_b_q <= NAB_NIBBLE_ZERO;
    end
    else if (start_i)
    begin
      op_q <= op_i;
      form_q <= (op_i == NAB_OP_ROTATE_RIGHT_THROUGH_CARRY) ? NAB_FORM_REG_MEM : form_i;
      if (op_i == NAB_OP_ROTATE_RIGHT_THROUGH_CARRY)
      begin
        temp_a_q <= reg_data_i;
        temp_b_q <= NAB_NIBBLE_ZERO;
      end
      else if (form_i == NAB_FORM_REG_MEM)
      begin
        temp_a_q <= reg_data_i;
        temp_b_q <= mem_data_i;
      end
      else
      begin
        temp_a_q <= mem_data_i;
        temp_b_q <= imm_i;
      end
    end
  end

  // Status flags; the ALU update wins over a same-cycle software write
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      carry_flag_q <= NAB_STATUS_RST[NAB_BIT_CARRY];
      zero_flag_q <= NAB_STATUS_RST[NAB_BIT_ZERO];
      compare_only_flag_q <= NAB_STATUS_RST[NAB_BIT_CMP];
      index_modify_enable_q <= NAB_STATUS_RST[NAB_BIT_IXE];
    end
    else
    begin
      if (sw_status_wr)
      begin
        carry_flag_q <= reg_wdata_i[NAB_BIT_CARRY];
        zero_flag_q <= reg_wdata_i[NAB_BIT_ZERO];
        compare_only_flag_q <= reg_wdata_i[NAB_BIT_CMP];
        index_modify_enable_q <= reg_wdata_i[NAB_BIT_IXE];
      end
      if (exec && is_arith)
      begin
        carry_flag_q <= arith_cy;
        if (!compare_only_flag_q)
        begin
          zero_flag_q <= (arith_res == NAB_NIBBLE_ZERO);
        end
        else if (arith_res != NAB_NIBBLE_ZERO)
        begin
          zero_flag_q <= 1'b0;
        end
      end
      if (exec && is_rot)
      begin
        carry_flag_q <= temp_a_q[0];
      end
      if (exec && is_test)
      begin
        compare_only_flag_q <= 1'b0;
      end
    end
  end

  // Decimal mode register
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      decimal_mode_q <= NAB_DEC_RST;
    end
    else if (reg_wr_i && (reg_addr_i == NAB_ADDR_MODE))
    begin
      decimal_mode_q <= reg_wdata_i[NAB_BIT_DEC];
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= NAB_NIBBLE_ZERO;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        NAB_ADDR_STATUS: reg_rdata_o <= {compare_only_flag_q, carry_flag_q,
                                         zero_flag_q, index_modify_enable_q};
        NAB_ADDR_MODE: reg_rdata_o <= {3'h0, decimal_mode_q};
        default: reg_rdata_o <= NAB_NIBBLE_ZERO;
      endcase
    end
    else
    begin
      reg_rdata_o <= NAB_NIBBLE_ZERO;
    end
  end

  // Execution outputs, one cycle after the execute cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      result_o <= NAB_NIBBLE_ZERO;
      wb_en_o <= 1'b0;
      wb_to_reg_o <= 1'b0;
      skip_o <= 1'b0;
      index_mod_o <= 1'b0;
    end
    else
    begin
      done_o <= exec;
      result_o <= exec ? alu_res : NAB_NIBBLE_ZERO;
      // Compare-only suppresses arithmetic store only; logic and rotate always store
      wb_en_o <= exec && ((is_arith && !compare_only_flag_q) || is_logic || is_rot);
      wb_to_reg_o <= exec && (form_q == NAB_FORM_REG_MEM) && !is_test && !is_cmp;
      skip_o <= exec && alu_skip;
      // Sequencer applies the index register when this is high
      index_mod_o <= exec && index_modify_enable_q;
    end
  end

  assign carry_flag_o = carry_flag_q;
  assign zero_flag_o = zero_flag_q;

  // Checks
  a_cmp_blocks_wb: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_arith && compare_only_flag_q |=> done_o && !wb_en_o)
    else $error("arithmetic stored while compare-only set");

  a_logic_keeps_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_logic && !sw_status_wr |=> $stable(carry_flag_q) && $stable(zero_flag_q)
      && wb_en_o)
    else $error("logical op changed flags or skipped store");

  a_test_clears_cmp: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_test |=> !compare_only_flag_q && !wb_en_o)
    else $error("bit test left compare-only set");

  a_rotate_carry: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_rot |=> carry_flag_q == $past(temp_a_q[0])
      && result_o == {$past(carry_flag_q), $past(temp_a_q[3:1])})
    else $error("rotate through carry wrong");

  a_bin_add_result: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && (op_q == NAB_OP_ADD) && !decimal_mode_q |=> {carry_flag_q, result_o}
      == $past(sum_ab))
    else $error("binary add result or carry wrong");

  a_dec_add_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && (op_q == NAB_OP_ADD) && decimal_mode_q && (sum_ab >= NAB_DEC_TEN)
      && (sum_ab < NAB_DEC_LIMIT) |=> carry_flag_q
      && result_o == 4'($past(sum_ab) - NAB_DEC_TEN))
    else $error("decimal add tens correction wrong");

  a_zero_hold_cmp: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_arith && compare_only_flag_q && !sw_status_wr |=>
      zero_flag_q == ($past(zero_flag_q) && ($past(arith_res) == NAB_NIBBLE_ZERO)))
    else $error("zero flag chain wrong under compare-only");

  a_compare_no_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_cmp && !sw_status_wr |=> $stable(carry_flag_q) && $stable(zero_flag_q)
      && !wb_en_o)
    else $error("compare changed flags or stored");

  a_operand_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_i && (form_i == NAB_FORM_MEM_IMM) && (op_i != NAB_OP_ROTATE_RIGHT_THROUGH_CARRY)
      |=> exec && temp_a_q == $past(mem_data_i) && temp_b_q == $past(imm_i) ##1 done_o)
    else $error("operands not latched or execution late");

  c_dec_overflow: cover property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_add && decimal_mode_q && (raw >= NAB_DEC_LIMIT));
  c_compare_skip: cover property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_cmp ##1 skip_o);
  c_cmp_chain: cover property (@(posedge core_clk_i) disable iff (rst_i)
    exec && is_arith && compare_only_flag_q ##1 exec && is_arith && compare_only_flag_q);

endmodule

// File: pkg/nab_pkg.sv
// Package for the nibble ALU: register map, flag positions, opcodes and states
package nab_pkg;

  // Register port map
  localparam logic [1:0] NAB_ADDR_STATUS = 2'h0;
  localparam logic [1:0] NAB_ADDR_MODE = 2'h1;

  // Status word bit positions
  localparam int NAB_BIT_IXE = 0;
  localparam int NAB_BIT_ZERO = 1;
  localparam int NAB_BIT_CARRY = 2;
  localparam int NAB_BIT_CMP = 3;
  // Mode register bit position
  localparam int NAB_BIT_DEC = 0;

  // Reset values
  localparam logic [3:0] NAB_STATUS_RST = 4'h0;
  localparam logic NAB_DEC_RST = 1'b0;
  localparam logic [3:0] NAB_NIBBLE_ZERO = 4'h0;

  // Decimal correction constants
  localparam logic [4:0] NAB_DEC_TEN = 5'h0A;
  localparam logic [4:0] NAB_DEC_LIMIT = 5'h14;
  localparam logic [4:0] NAB_DEC_HIGH = 5'h1C;
  localparam logic [4:0] NAB_DEC_HIGH_OFS = 5'h12;
  localparam logic [1:0] NAB_DEC_FOLD = 2'h2;
  localparam logic [1:0] NAB_DEC_TOP = 2'h3;

  // Operand forms
  localparam logic NAB_FORM_REG_MEM = 1'b0;
  localparam logic NAB_FORM_MEM_IMM = 1'b1;

  typedef enum logic [4:0] {
    NAB_OP_ADD,
    NAB_OP_SUM_WITH_CARRY_IN,
    NAB_OP_SUB,
    NAB_OP_DIFFERENCE_WITH_BORROW_IN,
    NAB_OP_AND,
    NAB_OP_OR,
    NAB_OP_XOR,
    NAB_OP_TEST_TRUE,
    NAB_OP_TEST_FALSE,
    NAB_OP_SKIP_EQ,
    NAB_OP_SKIP_NE,
    NAB_OP_SKIP_GE,
    NAB_OP_SKIP_LT,
    NAB_OP_ROTATE_RIGHT_THROUGH_CARRY
  } nab_op_t;

  typedef enum logic {
    NAB_ST_IDLE,
    NAB_ST_EXEC
  } nab_state_t;

endpackage

// File: verif/nab_seq_model.sv
// Partner model: one general register and one data memory word behind the ALU
`timescale 1ns/1ps

module nab_seq_model (
  input wire logic core_clk_i,
  input wire logic ld_i,
  input wire logic [3:0] ld_reg_i,
  input wire logic [3:0] ld_mem_i,
  input wire logic done_i,
  input wire logic wb_en_i,
  input wire logic wb_to_reg_i,
  input wire logic [3:0] result_i,
  output logic [3:0] reg_o,
  output logic [3:0] mem_o
);
  always_ff @(posedge core_clk_i)
  begin
    if (ld_i)
    begin
      reg_o <= ld_reg_i;
      mem_o <= ld_mem_i;
    end
    else if (done_i && wb_en_i)
    begin
      // Store lands only where the first operand came from
      if (wb_to_reg_i)
        reg_o <= result_i;
      else
        mem_o <= result_i;
    end
  end
endmodule

// File: verif/tb.sv
// Self-checking bench for the nibble ALU
`timescale 1ns/1ps

module tb;
  import nab_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  nab_op_t op = NAB_OP_ADD;
  logic form = 1'b0;
  logic [3:0] imm = 4'h0;
  logic [1:0] addr = 2'h0;
  logic [3:0] wdata = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ld = 1'b0;
  logic [3:0] ldr = 4'h0;
  logic [3:0] ldm = 4'h0;
  logic [3:0] rdata, res, rq, mq;
  logic done, wb, wtr, skip, ixm, cy, z;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  nab_alu uut (.core_clk_i(clk), .rst_i(rst), .start_i(start), .op_i(op), .form_i(form),
    .reg_data_i(rq), .mem_data_i(mq), .imm_i(imm), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .done_o(done), .result_o(res),
    .wb_en_o(wb), .wb_to_reg_o(wtr), .skip_o(skip), .index_mod_o(ixm),
    .carry_flag_o(cy), .zero_flag_o(z));

  nab_seq_model pm (.core_clk_i(clk), .ld_i(ld), .ld_reg_i(ldr), .ld_mem_i(ldm),
    .done_i(done), .wb_en_i(wb), .wb_to_reg_i(wtr), .result_i(res), .reg_o(rq), .mem_o(mq));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Sweep needs about 30k cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input string nm, input logic [1:0] a, input logic [3:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask

  // Loads register and memory, issues one op, waits for its answer
  task automatic run(input nab_op_t o, input logic f, input logic [3:0] r, m, i);
    @(posedge clk);
    ld <= 1'b1;
    ldr <= r;
    ldm <= m;
    @(posedge clk);
    ld <= 1'b0;
    op <= o;
    form <= f;
    imm <= i;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1 chk("done", 4'h1, {3'h0, done});
  endtask

  task automatic t_regs();
    rd_reg("status", NAB_ADDR_STATUS, 4'h0);
    rd_reg("mode", NAB_ADDR_MODE, 4'h0);
    wr_reg(2'h2, 4'hF);
    rd_reg("unmapped", 2'h2, 4'h0);
    wr_reg(NAB_ADDR_STATUS, 4'h6);
    #1 chk("flag_pins", 4'h3, {2'h0, cy, z});
    rd_reg("status", NAB_ADDR_STATUS, 4'h6);
    wr_reg(NAB_ADDR_MODE, 4'hF);
    rd_reg("mode", NAB_ADDR_MODE, 4'h1);
  endtask

  task automatic t_arith();
    logic [4:0] s;
    logic [3:0] a, b, e;
    logic ec, ez, ci, cmp, f;
    for (int d = 0; d < 2; d++)
    begin
      wr_reg(NAB_ADDR_MODE, d[3:0]);
      for (int k = 0; k < 2048; k++)
      begin
        a = k[3:0];
        b = k[7:4];
        cmp = k[10];
        ci = a[1] ^ b[0];
        f = a[0] ^ b[1];
        wr_reg(NAB_ADDR_STATUS, {cmp, ci, a[2], b[3]});
        if (k[9])
          s = {1'b0, a} - {1'b0, b} - (k[8] & ci);
        else
          s = {1'b0, a} + {1'b0, b} + (k[8] & ci);
        ec = s[4];
        e = s[3:0];
        if (d == 1 && !k[9])
        begin
          ec = s > 5'd9;
          if (s > 5'd27)
            e = 4'(s - 5'd18);
          else if (s > 5'd19)
            e = {2'b11, s[1:0] ^ 2'b10};
          else if (s > 5'd9)
            e = 4'(s - 5'd10);
        end
        else if (d == 1)
        begin
          ec = s > 5'd9;
          if (s > 5'd21)
            e = 4'(s + 5'd10);
          else if (s > 5'd9)
            e = {2'b11, s[1:0] ^ 2'b10};
        end
        ez = (e == 4'h0) && (!cmp || a[2]);
        run(nab_op_t'(k[9:8]), f, f ? 4'h5 : a, f ? a : b, b);
        chk("arith_res", e, res);
        chk("cy_z_wb_dst", {ec, ez, ~cmp, ~f}, {cy, z, wb, wtr});
        chk("ix_skip", {b[3], 3'h0}, {ixm, skip, 2'h0});
        @(posedge clk);
        #1 chk("stored", cmp ? a : e, f ? mq : rq);
      end
    end
  endtask

  task automatic t_logic();
    logic [3:0] a, b, e;
    for (int k = 0; k < 48; k++)
    begin
      a = 4'(k * 5);
      b = 4'(k * 3 + 7);
      wr_reg(NAB_ADDR_STATUS, {1'b1, k[0], k[1], 1'b0});
      e = (k % 3 == 0) ? (a & b) : (k % 3 == 1) ? (a | b) : (a ^ b);
      run(nab_op_t'(4 + k % 3), k[2], a, k[2] ? a : b, b);
      chk("logic_res", e, res);
      chk("logic_flags", {k[0], k[1], 1'b1, ~k[2]}, {cy, z, wb, wtr});
      chk("logic_skip", 4'h0, {3'h0, skip});
    end
  endtask

  task automatic t_skip();
    logic [3:0] a, b;
    logic [5:0] sk;
    int o;
    for (int k = 0; k < 120; k++)
    begin
      o = k % 6;
      a = k[3:0];
      b = k[4] ? a : {k[6:5], k[1:0]};
      sk = {a < b, a >= b, a != b, a == b, (a & b) == 4'h0, (a & b) == b};
      wr_reg(NAB_ADDR_STATUS, {1'b1, k[0], k[2], 1'b0});
      run(nab_op_t'(7 + o), 1'b1, 4'h9, a, b);
      chk("skip_wb", {sk[o], 1'b0, k[0], k[2]}, {skip, wb, cy, z});
      rd_reg("cmp_after", NAB_ADDR_STATUS, {o > 1, k[0], k[2], 1'b0});
    end
  endtask

  task automatic t_rot();
    logic [3:0] a;
    for (int k = 0; k < 32; k++)
    begin
      a = k[3:0];
      wr_reg(NAB_ADDR_STATUS, {1'b1, k[4], k[2], 1'b0});
      run(NAB_OP_ROTATE_RIGHT_THROUGH_CARRY, k[1], a, ~a, 4'hA);
      chk("rot_res", {k[4], a[3:1]}, res);
      chk("rot_flags", {a[0], k[2], 2'h3}, {cy, z, wb, wtr});
      @(posedge clk);
      #1 chk("rot_store", {k[4], a[3:1]}, rq);
    end
  endtask

  // Back-to-back compare-only chain: 3-3, 3-3-cy, 3-4-cy
  task automatic t_chain();
    wr_reg(NAB_ADDR_STATUS, 4'hA);
    @(posedge clk);
    ld <= 1'b1;
    ldm <= 4'h3;
    @(posedge clk);
    ld <= 1'b0;
    op <= NAB_OP_SUB;
    form <= 1'b1;
    imm <= 4'h3;
    start <= 1'b1;
    @(posedge clk);
    op <= NAB_OP_DIFFERENCE_WITH_BORROW_IN;
    @(posedge clk);
    imm <= 4'h4;
    #1 chk("chain_1", 4'h9, {done, wb, cy, z});
    @(posedge clk);
    start <= 1'b0;
    #1 chk("chain_2", 4'h9, {done, wb, cy, z});
    @(posedge clk);
    #1 chk("chain_3", 4'hA, {done, wb, cy, z});
    @(posedge clk);
    #1 chk("chain_mem", 4'h3, mq);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_arith();
    t_logic();
    t_skip();
    t_rot();
    t_chain();
    wrap_up();
  end
endmodule
